// >>> src/serial_clock_status.v
`timescale 1ns/1ps
`default_nettype none
`include "serial_defines.vh"

module serial_clock_status (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // wishbone slave
    input  wire [4:2]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // serial clock pin
    input  wire        sck_in,
    output reg         sck_out,
    output reg         sck_oe,
    // received bytes from the receiver datapath
    input  wire        rx_valid,
    input  wire [7:0]  rx_data,
    input  wire        rx_parity_err,
    input  wire        rx_framing_err,
    // flag set pulses from transmitter and receiver datapaths
    input  wire [7:0]  flag_set,
    // clocking towards the datapaths
    output reg         sample_tick,     // one pulse per base clock period
    output reg         clock_external,  // base clock taken from the pin
    // interrupt
    output reg         irq
);

    // bus decode
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;   // one access per ack
    wire wr  = req & wb_we_i;
    wire rd  = req & ~wb_we_i;

    // software-visible registers, plus the internal arm bits
    reg  [7:0]  control;        // select, reserved, mode
    reg  [7:0]  divider;        // internal base clock divide
    reg  [7:0]  flags;          // status bits 7:0 (bits 3:2 unused here)
    reg  [7:0]  armed;          // flag was read as one
    reg  [2:0]  irq_status;     // sticky events
    reg  [2:0]  irq_mask;       // enables

    // fifo state
    reg  [`FIFO_AW-1:0] wr_ptr;
    reg  [`FIFO_AW-1:0] rd_ptr;
    reg  [`FIFO_AW:0]   fill;           // 0..16
    reg  [3:0]          parity_fault_count;
    reg  [3:0]          framing_fault_count;
    wire [`FIFO_DW-1:0] stored_word;    // registered word from the store

    // pin synchroniser and edge finder
    reg        sck_s1, sck_s2, sck_s3;
    reg        sck_level;
    reg  [7:0] div_cnt;

    wire [1:0] sel       = control[`CTL_SEL_HI:`CTL_SEL_LO];
    wire       sync_mode = control[`CTL_SYNC_MODE];

    // pin direction decode, used only for the pin output enable
    function pin_drives;
        input       mode;
        input [1:0] code;
        begin
            if (mode) begin
                pin_drives = (code == `SEL_INT_NOPIN) | (code == `SEL_INT_PINOUT);
            end else begin
                pin_drives = (code == `SEL_INT_PINOUT);
            end
        end
    endfunction

    // external clock decode
    function pin_is_clock;
        input [1:0] code;
        begin
            pin_is_clock = (code == `SEL_EXT_PININ);
        end
    endfunction

    wire drive_now = pin_drives(sync_mode, sel);
    wire ext_now   = pin_is_clock(sel);

    // fifo push and pop
    wire fifo_full  = (fill == `FIFO_DEPTH);
    wire fifo_empty = (fill == 0);
    wire push       = rx_valid & ~fifo_full;
    wire overflow   = rx_valid & fifo_full;
    wire pop        = rd & (wb_adr_i == `OFS_RX_DATA) & ~fifo_empty;

    // the store reads the head for the next cycle; a word written to that same slot on
    // this edge is not visible through the store yet, so a copy of it is kept instead
    wire [`FIFO_AW-1:0] next_rd_ptr = pop ? rd_ptr + 4'h1 : rd_ptr;   // head slot after this edge
    wire [`FIFO_DW-1:0] push_word   = {rx_framing_err, rx_parity_err, rx_data};
    wire                bypass_hit  = push & (wr_ptr == next_rd_ptr); // new word becomes the head
    reg                 head_bypass;    // head was written on the last edge
    reg  [`FIFO_DW-1:0] bypass_word;    // copy of that word
    wire [`FIFO_DW-1:0] head_word   = head_bypass ? bypass_word : stored_word;
    wire head_par   = head_word[8] & ~fifo_empty;
    wire head_frm   = head_word[9] & ~fifo_empty;

    // storage; read address is the next head so the flop holds the head word after each edge
    rx_fifo_store u_store (
        .clock      (clock),
        .write_en   (push),
        .write_addr (wr_ptr),
        .write_data (push_word),
        .read_addr  (next_rd_ptr),
        .read_data  (stored_word)
    );

    // pointers, fill level and error counts
    always @(posedge clock) begin
        if (rst) begin
            wr_ptr              <= 4'h0;
            rd_ptr              <= 4'h0;
            fill                <= 5'h00;
            parity_fault_count  <= 4'h0;
            framing_fault_count <= 4'h0;
            head_bypass         <= 1'b0;
            bypass_word         <= 10'h000;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 4'h1;
            end
            head_bypass <= bypass_hit;
            bypass_word <= push_word;
            if (pop) begin
                rd_ptr <= rd_ptr + 4'h1;
            end
            if (push & ~pop) begin
                fill <= fill + 5'h01;
            end else if (pop & ~push) begin
                fill <= fill - 5'h01;
            end
            // four bits wrap, so a fifo full of errors reads zero
            parity_fault_count <= parity_fault_count
                                + {3'h0, push & rx_parity_err}
                                - {3'h0, pop & head_par};
            framing_fault_count <= framing_fault_count
                                 + {3'h0, push & rx_framing_err}
                                 - {3'h0, pop & head_frm};
        end
    end

    // control, divider and mask writes; byte lane 0 only
    always @(posedge clock) begin
        if (rst) begin
            control  <= `RESET_CONTROL;
            divider  <= `RESET_DIVIDER;
            irq_mask <= `RESET_IRQ;
        end else if (wr & wb_sel_i[0]) begin
            case (wb_adr_i)
                `OFS_CONTROL: begin
                    // the reserved bit never stores; software should order mode before select
                    control <= wb_dat_i[7:0] & ~(8'h01 << `CTL_RESERVED);
                end
                `OFS_DIVIDER: begin
                    divider <= wb_dat_i[7:0];
                end
                `OFS_IRQ_MASK: begin
                    irq_mask <= wb_dat_i[2:0];
                end
                default: begin
                    control <= control;
                end
            endcase
        end
    end

    // status flags: hardware sets, software clears after a read of one
    wire st_read  = rd & (wb_adr_i == `OFS_STATUS);
    wire st_write = wr & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0];
    wire [7:0] hw_set;
    assign hw_set[`ST_RX_IDLE]  = flag_set[`ST_RX_IDLE];
    assign hw_set[`ST_RX_FULL]  = flag_set[`ST_RX_FULL] | (push & (fill == `FIFO_DEPTH - 1));
    assign hw_set[`ST_PARITY]   = 1'b0;
    assign hw_set[`ST_FRAMING]  = 1'b0;
    assign hw_set[`ST_BREAK]    = flag_set[`ST_BREAK];
    assign hw_set[`ST_TX_EMPTY] = flag_set[`ST_TX_EMPTY];
    assign hw_set[`ST_TX_DONE]  = flag_set[`ST_TX_DONE];
    assign hw_set[`ST_RX_FAULT] = flag_set[`ST_RX_FAULT] | (push & (rx_parity_err | rx_framing_err));

    // per-flag next values; one process below owns both vectors
    wire [7:0] next_flags;
    wire [7:0] next_armed;
    localparam [15:0] status_init = `RESET_STATUS;   // low byte seeds the flags

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_flag
            if (i == `ST_PARITY || i == `ST_FRAMING) begin : g_ro
                // these two positions are live views of the head entry
                assign next_flags[i] = 1'b0;
                assign next_armed[i] = 1'b0;
            end else begin : g_rw
                wire clear_now = st_write & ~wb_dat_i[i] & armed[i];
                // a write of one is simply not a clear: it can never set; set wins over a clear
                assign next_flags[i] = hw_set[i] | (flags[i] & ~clear_now);
                // a fresh set must be read again before a zero write counts
                assign next_armed[i] = (clear_now | hw_set[i]) ? 1'b0 : (armed[i] | (st_read & flags[i]));
            end
        end
    endgenerate

    // flag and arm registers
    always @(posedge clock) begin
        if (rst) begin
            flags <= status_init[7:0];
            armed <= 8'h00;
        end else begin
            flags <= next_flags;
            armed <= next_armed;
        end
    end

    // assembled status word
    wire [15:0] status_word = {parity_fault_count, framing_fault_count,
                               flags[7:4], head_frm, head_par, flags[1:0]};

    // interrupt events, write one to clear, set wins
    wire [2:0] irq_evt;
    assign irq_evt[`IRQ_RX_BYTE]  = push;
    assign irq_evt[`IRQ_RX_FAULT] = push & (rx_parity_err | rx_framing_err);
    assign irq_evt[`IRQ_OVERFLOW] = overflow;
    wire [2:0] irq_clr = (wr & (wb_adr_i == `OFS_IRQ_STATUS) & wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

    // sticky events and level output
    always @(posedge clock) begin
        if (rst) begin
            irq_status <= `RESET_IRQ;
            irq        <= 1'b0;
        end else begin
            irq_status <= irq_evt | (irq_status & ~irq_clr);
            irq        <= |(irq_status & irq_mask);
        end
    end

    // bus answer: ack one cycle after the request, data with it
    always @(posedge clock) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h00000000;
            if (rd) begin
                case (wb_adr_i)
                    `OFS_CONTROL:    wb_dat_o <= {24'h000000, control};     // bit 2 always zero
                    `OFS_STATUS:     wb_dat_o <= {16'h0000, status_word};
                    `OFS_RX_DATA:    wb_dat_o <= {24'h000000, fifo_empty ? 8'h00 : head_word[7:0]};
                    `OFS_DIVIDER:    wb_dat_o <= {24'h000000, divider};
                    `OFS_IRQ_STATUS: wb_dat_o <= {29'h00000000, irq_status};
                    `OFS_IRQ_MASK:   wb_dat_o <= {29'h00000000, irq_mask};
                    default:         wb_dat_o <= 32'h00000000;              // unmapped reads zero
                endcase
            end
        end
    end

    // pin synchroniser: a change counts once stages two and three agree
    always @(posedge clock) begin
        if (rst) begin
            sck_s1    <= 1'b0;
            sck_s2    <= 1'b0;
            sck_s3    <= 1'b0;
            sck_level <= 1'b0;
        end else begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            if (sck_s2 == sck_s3) begin
                sck_level <= sck_s3;
            end
        end
    end

    wire ext_rise = (sck_s2 == sck_s3) & sck_s3 & ~sck_level;

    // internal base clock divider; the pin output toggles on each tick
    wire int_tick = (div_cnt == divider);

    always @(posedge clock) begin
        if (rst) begin
            div_cnt        <= 8'h00;
            sck_out        <= 1'b0;
            sck_oe         <= 1'b0;
            sample_tick    <= 1'b0;
            clock_external <= 1'b0;
        end else begin
            div_cnt <= int_tick ? 8'h00 : div_cnt + 8'h01;
            sck_oe  <= drive_now;
            if (int_tick) begin
                sck_out <= ~sck_out;                                // 16x bit rate in async
            end
            clock_external <= ext_now;
            // prohibited code stops the base clock rather than guessing
            if (sel == `SEL_PROHIBITED) begin
                sample_tick <= 1'b0;
            end else if (ext_now) begin
                sample_tick <= ext_rise;
            end else begin
                sample_tick <= int_tick & ~sck_out;                 // pin input ignored
            end
        end
    end

endmodule // serial_clock_status
`default_nettype wire

// >>> pkg/serial_defines.vh
`ifndef SERIAL_DEFINES_VH
`define SERIAL_DEFINES_VH

// register word offsets on the bus (address bits 4:2)
`define OFS_CONTROL     3'h0
`define OFS_STATUS      3'h1
`define OFS_RX_DATA     3'h2
`define OFS_DIVIDER     3'h3
`define OFS_IRQ_STATUS  3'h4
`define OFS_IRQ_MASK    3'h5

// control register fields
`define CTL_SEL_LO      0
`define CTL_SEL_HI      1
`define CTL_RESERVED    2
`define CTL_SYNC_MODE   7

// clock select codes
`define SEL_INT_NOPIN   2'h0
`define SEL_INT_PINOUT  2'h1
`define SEL_EXT_PININ   2'h2
`define SEL_PROHIBITED  2'h3

// status register fields
`define ST_RX_IDLE      0
`define ST_RX_FULL      1
`define ST_PARITY       2
`define ST_FRAMING      3
`define ST_BREAK        4
`define ST_TX_EMPTY     5
`define ST_TX_DONE      6
`define ST_RX_FAULT     7
`define ST_FRM_CNT_LO   8
`define ST_PAR_CNT_LO   12

// reset values
`define RESET_STATUS    16'h0060
`define RESET_CONTROL   8'h00
`define RESET_DIVIDER   8'h0f
`define RESET_IRQ       3'h0

// interrupt event bits
`define IRQ_RX_BYTE     0
`define IRQ_RX_FAULT    1
`define IRQ_OVERFLOW    2

// receive fifo shape
`define FIFO_DEPTH      16
`define FIFO_AW         4
`define FIFO_DW         10

`endif

// >>> src/rx_fifo_store.v
`timescale 1ns/1ps
`default_nettype none
`include "serial_defines.vh"

// receive fifo storage: one write port, registered read port
module rx_fifo_store (
    // clock
    input  wire                     clock,
    // write side
    input  wire                     write_en,   // store word this edge
    input  wire [`FIFO_AW-1:0]      write_addr,
    input  wire [`FIFO_DW-1:0]      write_data,
    // read side
    input  wire [`FIFO_AW-1:0]      read_addr,
    output reg  [`FIFO_DW-1:0]      read_data   // one cycle behind read_addr
);

    reg [`FIFO_DW-1:0] mem [0:`FIFO_DEPTH-1];   // no reset: contents are don't-care until written

    // write, and register the read so the head word comes out of a flop
    always @(posedge clock) begin
        if (write_en) begin
            mem[write_addr] <= write_data;
        end
        read_data <= mem[read_addr];
    end

endmodule // rx_fifo_store
`default_nettype wire

// >>> verif/far_serial_party.sv
`timescale 1ns/1ps
`default_nettype none
// far serial party: clocks the pin only within a burst, stands high between
module far_serial_party (
    // pin clock towards the block
    output logic sck_line
);
    initial sck_line = 1'b1; // idle level, never left floating
    // n rising edges at sixteen times the bit rate, 160 ns period
    task automatic send(input int n);
        #7; // keep pin edges away from the block's sampling edges
        repeat (n) begin
            #80 sck_line = 1'b0;
            #80 sck_line = 1'b1;
        end
    endtask
endmodule // far_serial_party
`default_nettype wire

// >>> verif/serial_clock_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// port checker; the control byte is rebuilt from bus writes
module serial_clock_status_monitor (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // bus
    input wire logic [4:2]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // pin and clocking
    input wire logic        sck_in,
    input wire logic        sck_oe,
    input wire logic        sample_tick,
    input wire logic        clock_external
);
    logic [7:0] ctl;                  // control shadow
    logic [2:0] age;                  // cycles since a control write
    wire        settled = age == 3'h7; // pin logic has surely caught up
    wire [1:0]  code = ctl[1:0];
    // shadow follows accepted control writes
    always_ff @(posedge clock) begin
        if (rst) begin
            ctl <= 8'h00;
            age <= 3'h0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 3'h0) begin
            ctl <= wb_dat_i[7:0];
            age <= 3'h0;
        end else if (!settled) begin
            age <= age + 3'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    AST_READ_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    AST_RSV_ZERO: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == 3'h0 |-> !wb_dat_o[2]) else $error("reserved bit read as one");
    AST_PIN_DRIVE: assert property (
        settled |-> sck_oe == (code == 2'h1 || (ctl[7] && !code[1]))) else $error("pin drive wrong");
    AST_PIN_INPUT: assert property (
        settled |-> clock_external == (code == 2'h2)) else $error("pin clock source wrong");
    AST_PROHIBITED: assert property (
        settled && code == 2'h3 |-> !sample_tick && !sck_oe) else $error("prohibited code active");
    AST_TICK_FROM_PIN: assert property (
        settled && code == 2'h2 && $rose(sck_in) |-> ##[2:6] sample_tick) else $error("pin edge lost");
    AST_PIN_STILL: assert property (
        (settled && code == 2'h2 && $stable(sck_in)) [*7] |-> !sample_tick) else $error("tick without pin");
    cover property (settled && code == 2'h2 && sample_tick);
    cover property (wb_ack_o && wb_we_i && wb_adr_i == 3'h1);
    cover property (settled && code == 2'h3);
endmodule // serial_clock_status_monitor
bind serial_clock_status serial_clock_status_monitor mon (.clock, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sck_in, .sck_oe, .sample_tick, .clock_external);
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_defines.vh"
module testbench;
    // bus master, receive stream, flag pulses
    logic        clock = 1'b0, rst = 1'b1;
    logic [4:2]  wb_adr_i = 3'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        rx_valid = 1'b0, rx_parity_err = 1'b0, rx_framing_err = 1'b0;
    logic [7:0]  rx_data = 8'h00, flag_set = 8'h00;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, sck_out, sck_oe, sample_tick, clock_external, irq, sck_line;
    wire         sck_in = sck_oe ? sck_out : sck_line; // block wins while it drives
    // bookkeeping
    int          failures = 0, cmp_count = 0, ticks = 0, i, b, k, n, pc, fc;
    logic [31:0] seed = 32'h1320, v, st;
    logic [31:0] exp_q[$], mask_q[$];
    logic [9:0]  fifo_q[$]; // parity, framing, byte of each stored entry
    always #10 clock = ~clock;
    serial_clock_status dut (.clock, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
        .wb_dat_o, .wb_ack_o, .sck_in, .sck_out, .sck_oe, .rx_valid, .rx_data, .rx_parity_err,
        .rx_framing_err, .flag_set, .sample_tick, .clock_external, .irq);
    far_serial_party far (.sck_line);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, failures);
    endtask
    // one classic cycle; a read leaves its masked expectation for the watcher
    task automatic bus(input logic [2:0] a, input logic we, input logic [31:0] d, input logic [31:0] m);
        int t;
        if (!we) exp_q.push_back(d & m);
        if (!we) mask_q.push_back(m);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= we ? d : 32'h0;
        wb_sel_i <= 4'hf;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 40);
        if (wb_ack_o !== 1'b1) begin
            failures++;
            stop_test();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask
    // edges until the pin output next changes
    task automatic span(output int c);
        logic last;
        last = sck_out;
        c = 0;
        while (sck_out === last && c < 99) begin
            @(posedge clock);
            c++;
        end
    endtask
    // watcher: each read answer settles the oldest note
    always @(posedge clock) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) chk("unnoted read", 0, 1);
            else chk("read data", exp_q.pop_front(), wb_dat_o & mask_q.pop_front());
        end
        if (sample_tick === 1'b1) ticks++;
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus(`OFS_STATUS, 1, 32'h0, 0);
        bus(`OFS_STATUS, 0, `RESET_STATUS, 32'hffffffff);
        bus(`OFS_CONTROL, 0, `RESET_CONTROL, 32'hffffffff);
        bus(`OFS_DIVIDER, 0, `RESET_DIVIDER, 32'hffffffff);
        bus(3'h6, 0, 32'h0, 32'hffffffff);
        bus(`OFS_STATUS, 1, 32'hffff, 0);
        bus(`OFS_STATUS, 0, `RESET_STATUS, 32'hffffffff);
        bus(`OFS_STATUS, 1, 32'h0, 0);
        bus(`OFS_STATUS, 0, 32'h0, 32'hffffffff);
        flag_set <= 8'hff;
        @(posedge clock);
        flag_set <= 8'h00;
        bus(`OFS_STATUS, 0, 32'h00f3, 32'hffffffff);
        bus(`OFS_STATUS, 1, 32'h0, 0);
        bus(`OFS_STATUS, 0, 32'h0, 32'hffffffff);
        done("status flags");
        // every mode and code; mode goes in first, reserved bit written high on purpose
        for (i = 0; i < 8; i++) begin
            bus(`OFS_CONTROL, 1, {i[2], 7'h0}, 0);
            bus(`OFS_CONTROL, 1, {i[2], 4'h0, 1'b1, i[1:0]}, 0);
            bus(`OFS_CONTROL, 0, {i[2], 5'h0, i[1:0]}, 32'hff);
            repeat (8) @(posedge clock);
            chk("pin drive", i[1:0] == 2'h1 || (i[2] && !i[1]), sck_oe);
            chk("pin input", i[1:0] == 2'h2, clock_external);
        end
        v = xs() % 15 + 1;
        bus(`OFS_CONTROL, 1, 32'h01, 0);
        bus(`OFS_DIVIDER, 1, v, 0);
        span(n);
        span(n);
        span(n);
        chk("pin clock half period", v + 1, n);
        bus(`OFS_CONTROL, 1, 32'h02, 0);
        repeat (16) @(posedge clock);
        ticks = 0;
        far.send(6);
        repeat (10) @(posedge clock);
        chk("pin ticks", 6, ticks);
        done("clock select");
        // fill past full with errored bytes, then drain; far side silent meanwhile
        for (b = 0; b < 2; b++) begin
            pc = 0;
            fc = 0;
            for (i = 0; i < 17; i++) begin
                v = xs();
                v[9 - b] = 1'b1;
                rx_valid <= 1'b1;
                {rx_parity_err, rx_framing_err, rx_data} <= v[9:0];
                if (i < 16) fifo_q.push_back(v[9:0]);
                if (i < 16) pc += v[9];
                if (i < 16) fc += v[8];
                @(posedge clock);
            end
            rx_valid <= 1'b0;
            bus(`OFS_IRQ_STATUS, 0, 32'h7, 32'hffffffff);
            bus(`OFS_IRQ_MASK, 1, 32'h4, 0);
            repeat (3) @(posedge clock);
            chk("irq raised", 1, irq);
            bus(`OFS_IRQ_MASK, 1, 32'h0, 0);
            repeat (3) @(posedge clock);
            chk("irq masked", 0, irq);
            bus(`OFS_IRQ_MASK, 1, 32'h4, 0);
            bus(`OFS_IRQ_STATUS, 1, 32'h7, 0);
            repeat (3) @(posedge clock);
            chk("irq cleared", 0, irq);
            for (k = 0; k < 16; k++) begin
                v = fifo_q.pop_front();
                st = {16'h0, pc[3:0], fc[3:0], 4'h0, v[8], v[9], 2'h0};
                bus(`OFS_STATUS, 0, st, 32'hffffff0c);
                bus(`OFS_STATUS, 1, 32'h0, 0);
                bus(`OFS_STATUS, 0, st, 32'hffffff0c);
                bus(`OFS_RX_DATA, 0, v, 32'hff);
                pc -= v[9];
                fc -= v[8];
            end
            bus(`OFS_STATUS, 0, 32'h0, 32'hffffff0c);
        end
        done("receive counts");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
